//--- mfi_far_model.sv
/* far side model: speed search and stop completion responder.
   assumes search and stop requests are levels synchronous to core_clk_i. */
`timescale 1ns/10ps
module mfi_far_model (
   input wire logic core_clk_i,
   input wire logic search_req_i,
   input wire logic stop_req_i,
   input wire logic [7:0] delay_i,
   input wire logic [15:0] speed_i,
   output logic search_done_o = 1'b0,
   output logic stop_done_o = 1'b0,
   output logic [15:0] search_speed_o
);
   int cnt = 0;
   // answer after delay_i cycles with a one-cycle pulse, so both prompt and slow ends are seen
   always @(posedge core_clk_i) begin
      search_done_o <= 1'b0;
      stop_done_o <= 1'b0;
      cnt <= 0;
      if ((search_req_i || stop_req_i) && !search_done_o && !stop_done_o) begin
         cnt <= cnt + 1;
         if (cnt >= int'(delay_i)) begin
            search_done_o <= search_req_i;
            stop_done_o <= stop_req_i;
         end
      end
   end
   // speed bus carries garbage outside the pulse so a stale capture shows up
   assign search_speed_o = search_done_o ? speed_i : ~speed_i;
endmodule

//--- mfi_input_ctrl.sv
/*
 multi-function input control: decodes the five multi-function terminals,
 picks local or remote command sources, handles baseblock with resume,
 overheat alarm, auxiliary analog enable and drive enable with stop.
 assumes all inputs are synchronous to core_clk_i; speed search itself
 and the output stage live outside and talk through the ports here.
*/
`timescale 1ns/10ps
// Overview of operation
// - local takes reference and run from panel
// - remote uses reference and run select parameters
// - each terminal does its own coded function
// - code 1 ON local, OFF remote
// - terminal local/remote locks out panel key
// - baseblock cuts output now, resumes after clear
// - search enabled: resume from measured motor speed
// - search disabled: resume from pre-block reference
// - code 8 blocks ON, code 9 OFF
// - code B ON shows overheat alarm
// - overheat alarm never drives fault contact
// - code C switches auxiliary analog input
// - code 6A enables or disables the drive
// - enable lost while running: selected stop method
module mfi_input_ctrl
   import mfi_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic clk_en_i,
   input wire logic [MFI_NUM_TERM-1:0] multi_function_terminals_i,
   input wire logic [MFI_NUM_TERM*MFI_CODE_W-1:0] terminal_function_select_i,
   input wire logic [MFI_SRC_W-1:0] reference_source_select_i,
   input wire logic [MFI_SRC_W-1:0] run_source_select_i,
   input wire logic [MFI_STOP_W-1:0] stop_method_select_i,
   input wire logic panel_lr_key_i,
   input wire logic [MFI_REF_W-1:0] panel_ref_i,
   input wire logic panel_run_i,
   input wire logic [(1 << MFI_SRC_W)*MFI_REF_W-1:0] src_ref_i,
   input wire logic [3:0] src_run_i,
   input wire logic speed_search_en_i,
   input wire logic search_done_i,
   input wire logic [MFI_REF_W-1:0] search_speed_i,
   input wire logic stop_done_i,
   input wire logic fault_i,
   output logic local_mode_o,
   output logic [MFI_REF_W-1:0] freq_ref_o,
   output logic run_cmd_o,
   output logic output_on_o,
   output logic search_req_o,
   output logic [MFI_REF_W-1:0] resume_ref_o,
   output logic stop_req_o,
   output logic [MFI_STOP_W-1:0] stop_method_o,
   output logic external_overheat_alarm_o,
   output logic fault_contact_o,
   output logic auxiliary_analog_input_en_o
);
   logic rst_s1_q;
   logic rst_n_q;
   logic [MFI_NUM_TERM-1:0] has_lr, lr_on, has_bb, bb_on, has_oh, oh_on, has_ai, ai_on, has_en, en_on;
   logic any_lr, lr_level, blk, drv_en, aux_en, local_d, run_d;
   logic [MFI_REF_W-1:0] ref_d;
   logic panel_key_q;
   logic key_local_q;
   logic local_q;
   logic [MFI_REF_W-1:0] ref_q;
   logic run_q;
   logic [MFI_REF_W-1:0] held_ref_q;
   logic [MFI_REF_W-1:0] resume_ref_q;
   logic oh_q;
   logic aux_q;
   logic fault_q;
   logic [MFI_STOP_W-1:0] stop_method_q;
   mfi_state_t state_q;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // one decoder per terminal, each fed its own select field
   genvar gi;
   generate
      for (gi = 0; gi < MFI_NUM_TERM; gi++) begin : g_term
         mfi_term_decode u_dec (
            .code_i(terminal_function_select_i[gi*MFI_CODE_W +: MFI_CODE_W]),
            .level_i(multi_function_terminals_i[gi]),
            .has_lr_o(has_lr[gi]),
            .lr_local_o(lr_on[gi]),
            .has_bb_o(has_bb[gi]),
            .bb_o(bb_on[gi]),
            .has_oh_o(has_oh[gi]),
            .oh_o(oh_on[gi]),
            .has_ai_o(has_ai[gi]),
            .ai_en_o(ai_on[gi]),
            .has_en_o(has_en[gi]),
            .drv_en_o(en_on[gi])
         );
      end
   endgenerate

   // combine terminals; unassigned drive enable and aux input fall back to enabled, the others to inactive
   always_comb begin
      any_lr = |has_lr;
      lr_level = |lr_on;
      blk = |bb_on;
      drv_en = (|has_en) ? |en_on : 1'b1;
      aux_en = (|has_ai) ? |ai_on : 1'b1;
   end

   // panel key edge; ignored while a terminal owns local/remote
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         panel_key_q <= 1'b0;
         key_local_q <= 1'b0;
      end else if (clk_en_i) begin
         panel_key_q <= panel_lr_key_i;
         if (panel_lr_key_i && !panel_key_q && !any_lr) begin
            key_local_q <= !key_local_q;
         end
      end
   end

   // source mux: operator in local, parameter-selected in remote
   always_comb begin
      local_d = any_lr ? lr_level : key_local_q;
      if (local_d) begin
         ref_d = panel_ref_i;
         run_d = panel_run_i;
      end else begin
         ref_d = src_ref_i[reference_source_select_i*MFI_REF_W +: MFI_REF_W];
         run_d = (run_source_select_i == MFI_SRC_OPERATOR) ? panel_run_i : src_run_i[run_source_select_i];
      end
   end

   // registered command outputs
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         local_q <= 1'b0;
         ref_q <= '0;
         run_q <= 1'b0;
      end else if (clk_en_i) begin
         local_q <= local_d;
         ref_q <= ref_d;
         run_q <= run_d;
      end
   end

   // alarm and aux enable; fault contact follows only real faults
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         oh_q <= 1'b0;
         aux_q <= 1'b1;
         fault_q <= 1'b0;
      end else if (clk_en_i) begin
         oh_q <= |oh_on;
         aux_q <= aux_en;
         fault_q <= fault_i;
      end
   end

   // run sequencer: baseblock wins over everything, then drive enable
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= MFI_ST_IDLE;
         held_ref_q <= '0;
         resume_ref_q <= '0;
         stop_method_q <= MFI_STOP_RAMP;
      end else if (clk_en_i) begin
         case (state_q)
            MFI_ST_IDLE: begin
               if (blk) begin
                  state_q <= MFI_ST_BLOCK;
               end else if (run_d && drv_en) begin
                  state_q <= MFI_ST_RUN;
               end
            end
            MFI_ST_RUN: begin
               if (blk) begin
                  held_ref_q <= ref_q;
                  state_q <= MFI_ST_BLOCK;
               end else if (!drv_en) begin
                  stop_method_q <= stop_method_select_i;
                  state_q <= MFI_ST_STOP;
               end else if (!run_d) begin
                  state_q <= MFI_ST_IDLE;
               end
               resume_ref_q <= ref_d;
            end
            MFI_ST_BLOCK: begin
               if (!blk) begin
                  if (speed_search_en_i) begin
                     state_q <= MFI_ST_SEARCH;
                  end else begin
                     resume_ref_q <= held_ref_q;
                     state_q <= run_d ? MFI_ST_RUN : MFI_ST_IDLE;
                  end
               end
            end
            MFI_ST_SEARCH: begin
               if (blk) begin
                  state_q <= MFI_ST_BLOCK;
               end else if (search_done_i) begin
                  resume_ref_q <= search_speed_i;
                  state_q <= MFI_ST_RUN;
               end
            end
            MFI_ST_STOP: begin
               if (blk) begin
                  state_q <= MFI_ST_BLOCK;
               end else if (stop_done_i) begin
                  state_q <= MFI_ST_IDLE;
               end
            end
            default: begin
               state_q <= MFI_ST_IDLE;
            end
         endcase
      end
   end

   // output is cut combinationally from the block input so a contactor
   // opened after the command never breaks live current
   assign output_on_o = (state_q == MFI_ST_RUN) && !blk;
   assign search_req_o = (state_q == MFI_ST_SEARCH);
   assign stop_req_o = (state_q == MFI_ST_STOP);
   assign local_mode_o = local_q;
   assign freq_ref_o = ref_q;
   assign run_cmd_o = run_q;
   assign resume_ref_o = resume_ref_q;
   assign stop_method_o = stop_method_q;
   assign external_overheat_alarm_o = oh_q;
   assign fault_contact_o = fault_q;
   assign auxiliary_analog_input_en_o = aux_q;

   bb_cuts_output_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      blk |-> !output_on_o) else $error("output on during baseblock");
   local_follows_term_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      (clk_en_i && any_lr) |=> (local_mode_o == $past(lr_level))) else $error("local mode wrong");
   local_uses_panel_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      (clk_en_i && local_d) |=> (freq_ref_o == $past(panel_ref_i) && run_cmd_o == $past(panel_run_i)))
      else $error("local sources wrong");
   key_locked_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      any_lr |=> $stable(key_local_q)) else $error("panel key acted while locked");
   oh_alarm_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      (clk_en_i && |oh_on) |=> external_overheat_alarm_o) else $error("overheat alarm missing");
   oh_no_fault_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      (clk_en_i && !fault_i) |=> !fault_contact_o) else $error("fault contact without fault");
   aux_follow_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      clk_en_i |=> (auxiliary_analog_input_en_o == $past(aux_en))) else $error("aux enable wrong");
   enable_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      (clk_en_i && state_q == MFI_ST_RUN && !blk && !drv_en)
      |=> (stop_req_o && stop_method_o == $past(stop_method_select_i)))
      else $error("drive disable did not stop");
   search_resume_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      (clk_en_i && search_req_o && !blk && search_done_i) |=> (resume_ref_o == $past(search_speed_i)))
      else $error("search speed not taken");
endmodule

//--- mfi_pkg.sv
/*
 package for the multi-function input control block: function codes,
 source select encodings, stop methods and widths.
 assumes nothing beyond a systemverilog compiler.
*/
package mfi_pkg;
   localparam int MFI_NUM_TERM = 5;
   localparam int MFI_CODE_W = 8;
   localparam int MFI_SRC_W = 2;
   localparam int MFI_STOP_W = 2;
   localparam int MFI_REF_W = 16;
   // terminal function codes (hexadecimal setting values)
   localparam logic [7:0] MFI_FN_LOCAL_REMOTE = 8'h01;
   localparam logic [7:0] MFI_FN_BB_NO = 8'h08;
   localparam logic [7:0] MFI_FN_BB_NC = 8'h09;
   localparam logic [7:0] MFI_FN_EXT_OH = 8'h0B;
   localparam logic [7:0] MFI_FN_AUX_AI = 8'h0C;
   localparam logic [7:0] MFI_FN_DRV_EN = 8'h6A;
   // source selections
   localparam logic [1:0] MFI_SRC_OPERATOR = 2'h0;
   localparam logic [1:0] MFI_SRC_TERMINAL = 2'h1;
   localparam logic [1:0] MFI_SRC_SERIAL = 2'h2;
   localparam logic [1:0] MFI_SRC_OPTION = 2'h3;
   // stop method selections
   localparam logic [1:0] MFI_STOP_RAMP = 2'h0;
   localparam logic [1:0] MFI_STOP_COAST = 2'h1;
   localparam logic [1:0] MFI_STOP_DCINJ = 2'h2;
   localparam logic [1:0] MFI_STOP_COAST_TMR = 2'h3;
   typedef enum logic [2:0] {
      MFI_ST_IDLE = 3'b000,
      MFI_ST_RUN = 3'b001,
      MFI_ST_BLOCK = 3'b010,
      MFI_ST_SEARCH = 3'b011,
      MFI_ST_STOP = 3'b100
   } mfi_state_t;
endpackage

//--- mfi_term_decode.sv
/*
 per-terminal decoder: reports which of the covered functions one
 multi-function terminal asserts, and whether it carries each function.
 assumes terminal levels are synchronous to core_clk_i (ON = 1).
*/
`timescale 1ns/10ps
module mfi_term_decode
   import mfi_pkg::*;
(
   input wire logic [MFI_CODE_W-1:0] code_i,
   input wire logic level_i,
   output logic has_lr_o,
   output logic lr_local_o,
   output logic has_bb_o,
   output logic bb_o,
   output logic has_oh_o,
   output logic oh_o,
   output logic has_ai_o,
   output logic ai_en_o,
   output logic has_en_o,
   output logic drv_en_o
);
   // each output is this terminal's own contribution only
   always_comb begin
      has_lr_o = (code_i == MFI_FN_LOCAL_REMOTE);
      lr_local_o = has_lr_o && level_i;
      has_bb_o = (code_i == MFI_FN_BB_NO) || (code_i == MFI_FN_BB_NC);
      bb_o = ((code_i == MFI_FN_BB_NO) && level_i) || ((code_i == MFI_FN_BB_NC) && !level_i);
      has_oh_o = (code_i == MFI_FN_EXT_OH);
      oh_o = has_oh_o && level_i;
      has_ai_o = (code_i == MFI_FN_AUX_AI);
      ai_en_o = has_ai_o && level_i;
      has_en_o = (code_i == MFI_FN_DRV_EN);
      drv_en_o = has_en_o && level_i;
   end
endmodule

//--- tb.sv
/* self-checking bench for the multi-function input control block.
   assumes mfi_pkg, mfi_input_ctrl and mfi_far_model are compiled first. */
`timescale 1ns/10ps
module tb;
   import mfi_pkg::*;
   logic core_clk_i = 1'b0, rstn_i = 1'b0, key = 1'b0, prun = 1'b0, ssen = 1'b0, fault = 1'b0;
   logic [4:0] term = '0;
   logic [39:0] fsel = '0;
   logic [1:0] refsel = '0, runsel = '0, stopsel = '0;
   logic [15:0] pref = '0, spd = '0, e0;
   logic [63:0] sref = '0;
   logic [3:0] srun = '0;
   logic [7:0] dly = 8'h01;
   logic key_loc = 1'b0;
   logic cen = 1'b1;
   int err_total = 0, tests_run = 0, ti;
   wire sdone, stdone, loc_o, run_o, on_o, sreq_o, stq_o, oh_o, fc_o, ai_o;
   wire [15:0] sspd, fref_o, rref_o;
   wire [1:0] sm_o;
   always #5 core_clk_i = ~core_clk_i;
   mfi_input_ctrl u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .clk_en_i(cen),
      .multi_function_terminals_i(term), .terminal_function_select_i(fsel), .reference_source_select_i(refsel),
      .run_source_select_i(runsel), .stop_method_select_i(stopsel), .panel_lr_key_i(key), .panel_ref_i(pref),
      .panel_run_i(prun), .src_ref_i(sref), .src_run_i(srun), .speed_search_en_i(ssen), .search_done_i(sdone),
      .search_speed_i(sspd), .stop_done_i(stdone), .fault_i(fault), .local_mode_o(loc_o), .freq_ref_o(fref_o),
      .run_cmd_o(run_o), .output_on_o(on_o), .search_req_o(sreq_o), .resume_ref_o(rref_o), .stop_req_o(stq_o),
      .stop_method_o(sm_o), .external_overheat_alarm_o(oh_o), .fault_contact_o(fc_o),
      .auxiliary_analog_input_en_o(ai_o));
   mfi_far_model u_far (.core_clk_i(core_clk_i), .search_req_i(sreq_o), .stop_req_i(stq_o), .delay_i(dly),
      .speed_i(spd), .search_done_o(sdone), .stop_done_o(stdone), .search_speed_o(sspd));
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // a function missing from every terminal counts as absent
   function automatic logic fn_has(input logic [7:0] c);
      fn_has = 1'b0;
      for (int i = 0; i < 5; i++) if (fsel[8*i+:8] == c) fn_has = 1'b1;
   endfunction
   function automatic logic fn_lvl(input logic [7:0] c);
      fn_lvl = 1'b0;
      for (int i = 0; i < 5; i++) if (fsel[8*i+:8] == c && term[i]) fn_lvl = 1'b1;
   endfunction
   // reference model of the source and flag outputs, compared once inputs have settled
   task automatic model_chk();
      logic loc, erun;
      int ru;
      repeat (3) @(posedge core_clk_i);
      #1;
      loc = fn_has(MFI_FN_LOCAL_REMOTE) ? fn_lvl(MFI_FN_LOCAL_REMOTE) : key_loc;
      ru = runsel;
      erun = (loc || ru == 0) ? prun : srun[ru];
      chk("local_mode", loc_o, loc);
      chk("freq_ref", fref_o, loc ? pref : sref[16*refsel+:16]);
      chk("run_cmd", run_o, erun);
      chk("overheat", oh_o, fn_lvl(MFI_FN_EXT_OH));
      chk("fault_contact", fc_o, fault);
      chk("aux_en", ai_o, fn_has(MFI_FN_AUX_AI) ? fn_lvl(MFI_FN_AUX_AI) : 1'b1);
   endtask
   task automatic press_key();
      @(posedge core_clk_i) key <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      key <= 1'b0;
      if (!fn_has(MFI_FN_LOCAL_REMOTE)) key_loc = !key_loc;
   endtask
   // bounded wait: 0 output on, 1 search request, 2 stop request
   // sampling 1 ns late keeps clear of the edge that launches the output
   task automatic wait_for(input int w, input logic v);
      logic s;
      s = 1'b0;
      for (int n = 0; n < 60; n++) begin
         #1;
         s = (w == 0) ? on_o : (w == 1) ? sreq_o : stq_o;
         if (s === v) break;
         @(posedge core_clk_i);
      end
      if (s !== v) begin
         err_total++;
         $display("[FAIL] wait %0d expected %b seen %b", w, v, s);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      $display("watchdog expired");
      end_of_test();
   end
   initial begin
      void'($urandom(37685));
      repeat (8) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      // every remote source pairing, no terminal assigned
      for (int s = 0; s < 16; s++) begin
         @(posedge core_clk_i);
         refsel <= s[1:0];
         runsel <= s[3:2];
         sref <= 64'({$urandom, $urandom});
         srun <= 4'($urandom);
         pref <= 16'($urandom);
         prun <= 1'($urandom);
         model_chk();
      end
      press_key();
      model_chk();
      press_key();
      model_chk();
      $display("test sources done");
      // terminal local/remote, alarm and aux input on shuffled terminals
      ti = $urandom_range(4);
      @(posedge core_clk_i);
      fsel[8*ti+:8] <= MFI_FN_LOCAL_REMOTE;
      fsel[8*((ti+1)%5)+:8] <= MFI_FN_EXT_OH;
      fsel[8*((ti+2)%5)+:8] <= MFI_FN_AUX_AI;
      for (int k = 0; k < 12; k++) begin
         @(posedge core_clk_i);
         term <= 5'($urandom);
         fault <= 1'($urandom);
         pref <= 16'($urandom);
         prun <= 1'($urandom);
         model_chk();
      end
      @(posedge core_clk_i) term <= 5'h00;
      press_key();
      model_chk();
      $display("test terminals done");
      // baseblock open and closed contact, with and without speed search
      for (int b = 0; b < 4; b++) begin
         @(posedge core_clk_i);
         fsel <= {32'h0, b[0] ? MFI_FN_BB_NC : MFI_FN_BB_NO};
         term <= {4'h0, b[0]};
         ssen <= b[1];
         refsel <= 2'h0;
         runsel <= 2'h0;
         prun <= 1'b1;
         wait_for(0, 1'b1);
         e0 = sref[15:0];
         chk("run_on", on_o, 1'b1);
         @(posedge core_clk_i) term[0] <= !b[0];
         spd <= 16'($urandom);
         dly <= 8'($urandom_range(20));
         #1 chk("block_off", on_o, 1'b0);
         repeat (3) @(posedge core_clk_i);
         #1 chk("block_hold", on_o, 1'b0);
         @(posedge core_clk_i) sref <= 64'({$urandom, $urandom});
         @(posedge core_clk_i) term[0] <= b[0];
         if (b[1]) begin
            wait_for(1, 1'b1);
            chk("search_req", sreq_o, 1'b1);
            wait_for(0, 1'b1);
            chk("resume_ref", rref_o, spd);
         end else begin
            wait_for(0, 1'b1);
            chk("resume_ref", rref_o, e0);
         end
         chk("resumed", on_o, 1'b1);
      end
      $display("test baseblock done");
      // drive enable with each stop method
      for (int m = 0; m < 4; m++) begin
         @(posedge core_clk_i);
         fsel <= {32'h0, MFI_FN_DRV_EN};
         term <= 5'h00;
         stopsel <= m[1:0];
         dly <= 8'h14;
         repeat (2) @(posedge core_clk_i);
         wait_for(2, 1'b0);
         repeat (4) @(posedge core_clk_i);
         #1 chk("disabled", on_o, 1'b0);
         @(posedge core_clk_i) term <= 5'h01;
         wait_for(0, 1'b1);
         chk("enabled", on_o, 1'b1);
         @(posedge core_clk_i) term <= 5'h00;
         wait_for(2, 1'b1);
         @(posedge core_clk_i) stopsel <= ~m[1:0];
         repeat (2) @(posedge core_clk_i);
         #1 chk("stop_req", stq_o, 1'b1);
         chk("stop_method", sm_o, m[1:0]);
      end
      $display("test drive enable done");
      // clock enable low freezes the gated registers, so a fault and a new reference wait and a key press is missed
      @(posedge core_clk_i) cen <= 1'b0;
      fault <= !fault;
      sref <= ~sref;
      key <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      #1 chk("freeze_fault", fc_o, !fault);
      chk("freeze_ref", fref_o, ~sref[15:0]);
      @(posedge core_clk_i) cen <= 1'b1;
      key <= 1'b0;
      model_chk();
      $display("test clock enable done");
      end_of_test();
   end
endmodule
